// ### pdio_regs.vh
/*
 * constants for the digital i/o and counter card core: port widths, counter
 * modes, clock divider counts and reset values.
 * assumes a single 100 MHz system clock; included by the core only.
 */
`ifndef PDIO_REGS_VH
`define PDIO_REGS_VH

`define PDIO_PORT_W        16
`define PDIO_ID_W          4
`define PDIO_CNT_W         16
`define PDIO_SEL_W         2
`define PDIO_SEL_2MHZ      2'h0
`define PDIO_SEL_1MHZ      2'h1
`define PDIO_SEL_500KHZ    2'h2
`define PDIO_SEL_250KHZ    2'h3
`define PDIO_CLK_HZ        100000000
`define PDIO_BASE_HZ       4000000
`define PDIO_PRE_W         8
`define PDIO_PRE_4M        8'h19
`define PDIO_DEC_W         4
`define PDIO_DEC_LAST      4'h9
`define PDIO_ZERO16        16'h0000
`define PDIO_ONE16         16'h0001
`define PDIO_MODE_W        2
`define PDIO_MODE_EVENT    2'h0
`define PDIO_MODE_RATE     2'h1
`define PDIO_MODE_ONESHOT  2'h2

`endif

// ### pdio_card.v
/*
 * digital i/o and counter card core: two latched 16-bit outputs, two 16-bit
 * inputs with optional strobe latch, six 16-bit counters (three general, one
 * event, two cascaded pacer), selectable clock source with decade outputs,
 * card id and an active-low level interrupt request.
 * assumes all pins synchronous to clk; the host bridge decodes its own
 * accesses and presents write strobes and read data paths as plain ports.
 */
`timescale 1ns/10ps
`include "pdio_regs.vh"

// ===================================================================
// counter channel
// ===================================================================
module pdio_counter (
    input  wire                      clk,
    input  wire                      reset_n,
    input  wire                      tick,
    input  wire                      gate,
    input  wire [`PDIO_MODE_W-1:0]   mode,
    input  wire                      load,
    input  wire [`PDIO_CNT_W-1:0]    load_value,
    output reg  [`PDIO_CNT_W-1:0]    count,
    output reg                       out
);
    reg [`PDIO_CNT_W-1:0] reload;
    reg                   armed;

    always @(posedge clk) begin
        if (!reset_n) begin
            count  <= `PDIO_ZERO16;
            reload <= `PDIO_ZERO16;
            out    <= 1'b0;
            armed  <= 1'b0;
        end else if (load) begin
            count  <= load_value;
            reload <= load_value;
            out    <= 1'b0;
            armed  <= 1'b1;
        end else if (tick && gate && armed) begin
            // terminal count: rate mode reloads and pulses, others stop high
            if (count == `PDIO_ONE16) begin
                out <= 1'b1;
                if (mode == `PDIO_MODE_RATE) begin
                    count <= reload;
                end else begin
                    count <= `PDIO_ZERO16;
                    armed <= 1'b0;
                end
            end else begin
                count <= count - `PDIO_ONE16;
                if (mode == `PDIO_MODE_RATE)
                    out <= 1'b0;
            end
        end else if (mode == `PDIO_MODE_RATE && tick) begin
            out <= 1'b0;
        end
    end
endmodule

// ===================================================================
// top level
// ===================================================================
// Summary of operation
// - all digital outputs except int_n are driven low while host reset is low.
// - input reads are blocked during reset, enabled once reset returns high.
// - an external strobe captures input pins into a latch read by host.
// - with strobe unused, live input pins pass straight through to reads.
// - two 16-bit input ports and two 16-bit output ports.
// - three general 16-bit counters for measurement, counting and pulses.
// - event channel counts external pulses, output raises event trigger at count.
// - two cascaded 16-bit stages on 4 MHz form the 32-bit pacer trigger.
// - base clock 2M/1M/500k/250k with divide-by-10 and -100 outputs on pads.
// - a 4-bit switch card id is readable by host software.
// - interrupt output active-low level from three equal-priority triggers.
module pdio_card (
    input  wire                        clk,
    input  wire                        reset_n,
    input  wire                        out_lo_we,
    input  wire                        out_hi_we,
    input  wire [`PDIO_PORT_W-1:0]     out_wdata,
    output reg  [`PDIO_PORT_W-1:0]     out_lo_pins,
    output reg  [`PDIO_PORT_W-1:0]     out_hi_pins,
    input  wire [`PDIO_PORT_W-1:0]     in_lo_pins,
    input  wire [`PDIO_PORT_W-1:0]     in_hi_pins,
    input  wire                        strobe_enable,
    input  wire                        strobe,
    output reg  [`PDIO_PORT_W-1:0]     in_lo_rdata,
    output reg  [`PDIO_PORT_W-1:0]     in_hi_rdata,
    input  wire [`PDIO_ID_W-1:0]       card_id_switch,
    output reg  [`PDIO_ID_W-1:0]       card_id,
    input  wire [`PDIO_SEL_W-1:0]      clock_select_jumper,
    output reg  [2:0]                  clock_output_pads,
    input  wire [5:0]                  cnt_load,
    input  wire [`PDIO_CNT_W-1:0]      cnt_load_value,
    input  wire [`PDIO_MODE_W*3-1:0]   gp_mode,
    input  wire [2:0]                  gp_clk_in,
    input  wire [2:0]                  gp_gate,
    output wire [2:0]                  gp_out,
    output wire [`PDIO_CNT_W*3-1:0]    gp_count,
    input  wire                        event_in,
    input  wire                        external_irq_source,
    output wire                        event_irq_source,
    output wire                        timer_irq_source,
    output wire [`PDIO_CNT_W-1:0]      event_count,
    output wire                        int_n
);
    // ===============================================================
    // output ports
    // ===============================================================
    always @(posedge clk) begin
        if (!reset_n) begin
            out_lo_pins <= `PDIO_ZERO16;
            out_hi_pins <= `PDIO_ZERO16;
        end else begin
            if (out_lo_we)
                out_lo_pins <= out_wdata;
            if (out_hi_we)
                out_hi_pins <= out_wdata;
        end
    end

    // ===============================================================
    // input ports
    // ===============================================================
    reg [`PDIO_PORT_W-1:0] latch_lo;
    reg [`PDIO_PORT_W-1:0] latch_hi;
    reg                    strobe_d;

    always @(posedge clk) begin
        if (!reset_n) begin
            latch_lo    <= `PDIO_ZERO16;
            latch_hi    <= `PDIO_ZERO16;
            strobe_d    <= 1'b0;
            in_lo_rdata <= `PDIO_ZERO16;
            in_hi_rdata <= `PDIO_ZERO16;
            card_id     <= 4'h0;
        end else begin
            strobe_d <= strobe;
            card_id  <= card_id_switch;
            if (strobe && !strobe_d) begin
                latch_lo <= in_lo_pins;
                latch_hi <= in_hi_pins;
            end
            // strobe unused means the read path is transparent
            in_lo_rdata <= strobe_enable ? latch_lo : in_lo_pins;
            in_hi_rdata <= strobe_enable ? latch_hi : in_hi_pins;
        end
    end

    // ===============================================================
    // 4 MHz base and selectable clock source
    // ===============================================================
    reg [`PDIO_PRE_W-1:0] pre;
    reg [1:0]             base_div;
    reg [`PDIO_DEC_W-1:0] dec10;
    reg [`PDIO_DEC_W-1:0] dec100;
    wire                  tick_4m = (pre == `PDIO_PRE_4M - 8'h01);
    wire                  tick_1m = tick_4m && (base_div == 2'h3);
    reg [1:0]             slow_div;
    reg                   sel_tick;

    // pads toggle, so the selected tick must run at twice the pad frequency
    always @* begin
        case (clock_select_jumper)
            `PDIO_SEL_2MHZ:   sel_tick = tick_4m;
            `PDIO_SEL_1MHZ:   sel_tick = tick_4m && base_div[0];
            `PDIO_SEL_500KHZ: sel_tick = tick_1m;
            default:          sel_tick = tick_1m && slow_div[0];
        endcase
    end

    wire      wrap10  = sel_tick && (dec10 == `PDIO_DEC_LAST);
    wire      wrap100 = wrap10 && (dec100 == `PDIO_DEC_LAST);

    always @(posedge clk) begin
        if (!reset_n) begin
            pre               <= 8'h00;
            base_div          <= 2'h0;
            slow_div          <= 2'h0;
            dec10             <= 4'h0;
            dec100            <= 4'h0;
            clock_output_pads <= 3'h0;
        end else begin
            pre <= tick_4m ? 8'h00 : pre + 8'h01;
            if (tick_4m)
                base_div <= base_div + 2'h1;
            if (tick_1m)
                slow_div <= slow_div + 2'h1;
            if (sel_tick) begin
                clock_output_pads[0] <= ~clock_output_pads[0];
                dec10 <= (dec10 == `PDIO_DEC_LAST) ? 4'h0 : dec10 + 4'h1;
            end
            if (wrap10) begin
                clock_output_pads[1] <= ~clock_output_pads[1];
                dec100 <= (dec100 == `PDIO_DEC_LAST) ? 4'h0 : dec100 + 4'h1;
            end
            if (wrap100)
                clock_output_pads[2] <= ~clock_output_pads[2];
        end
    end

    // ===============================================================
    // counters: edges on slow pins become one-cycle ticks
    // ===============================================================
    reg [2:0] gp_clk_d;
    reg       event_d;
    always @(posedge clk) begin
        if (!reset_n) begin
            gp_clk_d <= 3'h0;
            event_d  <= 1'b0;
        end else begin
            gp_clk_d <= gp_clk_in;
            event_d  <= event_in;
        end
    end
    wire [2:0] gp_tick = gp_clk_in & ~gp_clk_d;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gp
            pdio_counter u_cnt (
                .clk        (clk),
                .reset_n    (reset_n),
                .tick       (gp_tick[g]),
                .gate       (gp_gate[g]),
                .mode       (gp_mode[g*`PDIO_MODE_W +: `PDIO_MODE_W]),
                .load       (cnt_load[g]),
                .load_value (cnt_load_value),
                .count      (gp_count[g*`PDIO_CNT_W +: `PDIO_CNT_W]),
                .out        (gp_out[g])
            );
        end
    endgenerate

    pdio_counter u_event (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (event_in && !event_d),
        .gate       (1'b1),
        .mode       (`PDIO_MODE_EVENT),
        .load       (cnt_load[3]),
        .load_value (cnt_load_value),
        .count      (event_count),
        .out        (event_irq_source)
    );

    wire [`PDIO_CNT_W-1:0] pacer_lo_count;
    wire                   pacer_lo_out;
    reg                    pacer_lo_d;
    always @(posedge clk) begin
        if (!reset_n)
            pacer_lo_d <= 1'b0;
        else
            pacer_lo_d <= pacer_lo_out;
    end

    pdio_counter pacer_low_stage (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (tick_4m),
        .gate       (1'b1),
        .mode       (`PDIO_MODE_RATE),
        .load       (cnt_load[4]),
        .load_value (cnt_load_value),
        .count      (pacer_lo_count),
        .out        (pacer_lo_out)
    );

    pdio_counter pacer_high_stage (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (pacer_lo_out && !pacer_lo_d),
        .gate       (1'b1),
        .mode       (`PDIO_MODE_RATE),
        .load       (cnt_load[5]),
        .load_value (cnt_load_value),
        .count      (),
        .out        (timer_irq_source)
    );

    // ===============================================================
    // interrupt request
    // ===============================================================
    // gating lives in the host bridge, inversion is done here; all three share one level
    assign int_n = ~(external_irq_source | event_irq_source | timer_irq_source);
endmodule

// ### pdio_card_asserts.sv
/* port checker for the digital i/o and counter card core.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
// ==========
// checker
module pdio_card_asserts (
    input wire        clk,
    input wire        reset_n,
    input wire        out_lo_we,
    input wire        out_hi_we,
    input wire [15:0] out_wdata,
    input wire [15:0] out_lo_pins,
    input wire [15:0] out_hi_pins,
    input wire [15:0] in_lo_pins,
    input wire [15:0] in_lo_rdata,
    input wire        strobe_enable,
    input wire        strobe,
    input wire [3:0]  card_id_switch,
    input wire [3:0]  card_id,
    input wire [5:0]  cnt_load,
    input wire        external_irq_source,
    input wire        event_irq_source,
    input wire        timer_irq_source,
    input wire        int_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // reset checks must run while reset is low, so they drop the default
    a_out_rst_low: assert property (disable iff (1'b0)
        !reset_n |=> out_lo_pins == 16'h0000 && out_hi_pins == 16'h0000) else $error("outputs not cleared");
    a_in_rst_zero: assert property (disable iff (1'b0)
        !reset_n |=> in_lo_rdata == 16'h0000) else $error("input read not blocked in reset");
    a_out_lo_write: assert property (out_lo_we |=> out_lo_pins == $past(out_wdata))
        else $error("low output write lost");
    a_out_hold: assert property (!out_lo_we && !out_hi_we |=> $stable(out_lo_pins) && $stable(out_hi_pins))
        else $error("output changed without write");
    a_in_pass: assert property (!strobe_enable && $past(!strobe_enable) |=> in_lo_rdata == $past(in_lo_pins))
        else $error("transparent read wrong");
    a_latch_hold: assert property ((strobe_enable && !strobe)[*4] |=> $stable(in_lo_rdata))
        else $error("latched read moved without strobe");
    a_card_id_copy: assert property (1'b1 |=> card_id == $past(card_id_switch))
        else $error("card id wrong");
    a_int_level: assert property (int_n == !(event_irq_source || timer_irq_source || external_irq_source))
        else $error("interrupt output wrong");
    a_event_stand: assert property (event_irq_source && !cnt_load[3] |=> event_irq_source)
        else $error("event trigger dropped");
endmodule

bind pdio_card pdio_card_asserts chk_u (.clk(clk), .reset_n(reset_n), .out_lo_we(out_lo_we),
    .out_hi_we(out_hi_we), .out_wdata(out_wdata), .out_lo_pins(out_lo_pins), .out_hi_pins(out_hi_pins),
    .in_lo_pins(in_lo_pins), .in_lo_rdata(in_lo_rdata), .strobe_enable(strobe_enable), .strobe(strobe),
    .card_id_switch(card_id_switch), .card_id(card_id), .cnt_load(cnt_load),
    .external_irq_source(external_irq_source), .event_irq_source(event_irq_source),
    .timer_irq_source(timer_irq_source), .int_n(int_n));

// ### pdio_field_src.sv
/* field side pulse source for counter clock and event lines.
   the bench raises one fire bit for one cycle per pulse. */
`timescale 1ns/10ps
// ==========
// pulse source
module pdio_field_src (
    input  wire       clk,
    input  wire [3:0] fire,
    output reg  [3:0] lines
);
    // idle low so every pulse gives the counters one clean rising edge
    initial lines = 4'h0;
    always @(posedge clk) begin
        lines <= fire;
    end
endmodule

// ### pdio_card_tb.sv
/* self-checking bench for the card core.
   assumes pdio_field_src drives counter clocks and the event line. */
`timescale 1ns/10ps
// ==========
// bench
module pdio_card_tb;
    reg         clk = 1'b0, reset_n = 1'b0, out_lo_we = 1'b0, out_hi_we = 1'b0;
    reg         strobe_enable = 1'b0, strobe = 1'b0, ext = 1'b0;
    reg  [15:0] out_wdata = 16'h0000, in_lo = 16'h0000, in_hi = 16'h0000, ld_val = 16'h0000;
    reg  [3:0]  id_sw = 4'h0, fire = 4'h0;
    reg  [1:0]  sel = 2'h1;
    reg  [5:0]  ld = 6'h00, gp_mode = 6'h00;
    wire [15:0] out_lo, out_hi, rd_lo, rd_hi, ev_cnt;
    wire [47:0] gp_cnt;
    wire [3:0]  card_id, lines;
    wire [2:0]  pads, gp_out;
    wire        ev_irq, tm_irq, int_n;
    int         failures = 0, total_checks = 0;
    always #5 clk = ~clk;
    pdio_field_src src_u (.clk(clk), .fire(fire), .lines(lines));
    pdio_card dut_u (.clk(clk), .reset_n(reset_n), .out_lo_we(out_lo_we), .out_hi_we(out_hi_we),
        .out_wdata(out_wdata), .out_lo_pins(out_lo), .out_hi_pins(out_hi), .in_lo_pins(in_lo),
        .in_hi_pins(in_hi), .strobe_enable(strobe_enable), .strobe(strobe), .in_lo_rdata(rd_lo),
        .in_hi_rdata(rd_hi), .card_id_switch(id_sw), .card_id(card_id), .clock_select_jumper(sel),
        .clock_output_pads(pads), .cnt_load(ld), .cnt_load_value(ld_val), .gp_mode(gp_mode),
        .gp_clk_in(lines[2:0]), .gp_gate(3'h7), .gp_out(gp_out), .gp_count(gp_cnt),
        .event_in(lines[3]), .external_irq_source(ext), .event_irq_source(ev_irq),
        .timer_irq_source(tm_irq), .event_count(ev_cnt), .int_n(int_n));
    task tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task check(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task step(input int n); repeat (n) @(negedge clk); endtask
    task pulse(input [3:0] m); fire = m; step(1); fire = 4'h0; step(3); endtask
    task load(input int i, input [15:0] v); ld = 6'h01 << i; ld_val = v; step(1); ld = 6'h00; step(1); endtask
    function logic pick(input int k); pick = (k < 3) ? pads[k] : tm_irq; endfunction
    // cycles between two rising edges of a pad or the pacer trigger
    task rise(input int k, output int n);
        logic p, c;
        n = 0;
        p = pick(k);
        do begin
            @(negedge clk);
            n++;
            c = pick(k);
            if (c === 1'b1 && p === 1'b0) break;
            p = c;
        end while (n < 20000);
        if (n >= 20000) begin
            failures++;
            $display("BAD wait expected edge seen none");
            tally_and_finish;
        end
    endtask
    task period(input string nm, input int k, input int e);
        int n;
        repeat (3) rise(k, n);
        check(nm, e, n);
        @(negedge clk);
    endtask
    task t_out;
        out_wdata = 16'hA5C3; out_lo_we = 1'b1; step(1);
        out_wdata = 16'h5A3C; out_lo_we = 1'b0; out_hi_we = 1'b1; step(1);
        out_hi_we = 1'b0; out_wdata = 16'hFFFF; step(2);
        check("out_lo", 16'hA5C3, out_lo);
        check("out_hi", 16'h5A3C, out_hi);
        $display("test outputs done");
    endtask
    task t_rst;
        in_lo = 16'h00C3; reset_n = 1'b0; step(2);
        check("out_lo", 16'h0000, out_lo);
        check("out_hi", 16'h0000, out_hi);
        check("rd_lo", 16'h0000, rd_lo);
        reset_n = 1'b1; step(2);
        check("rd_lo", 16'h00C3, rd_lo);
        $display("test reset done");
    endtask
    task t_in;
        in_lo = 16'h1234; in_hi = 16'h8001; step(2);
        check("rd_lo", 16'h1234, rd_lo);
        check("rd_hi", 16'h8001, rd_hi);
        in_lo = 16'h0F0F; strobe_enable = 1'b1; step(1); strobe = 1'b1; step(1);
        strobe = 1'b0; in_lo = 16'hBEEF; step(4);
        check("rd_latch", 16'h0F0F, rd_lo);
        strobe = 1'b1; step(1); strobe = 1'b0; step(4);
        check("rd_latch", 16'hBEEF, rd_lo);
        strobe_enable = 1'b0; id_sw = 4'hA; step(2);
        check("card_id", 16'h000A, card_id);
        $display("test inputs done");
    endtask
    task t_evt;
        load(3, 16'h0003); pulse(4'h8); pulse(4'h8);
        check("ev_irq", 16'h0000, ev_irq);
        check("ev_cnt", 16'h0001, ev_cnt);
        pulse(4'h8);
        check("ev_irq", 16'h0001, ev_irq);
        check("int_n", 16'h0000, int_n);
        pulse(4'h8);
        check("ev_irq", 16'h0001, ev_irq);
        load(3, 16'h0003); step(2);
        check("ev_irq", 16'h0000, ev_irq);
        ext = 1'b1; step(1);
        check("int_n", 16'h0000, int_n);
        ext = 1'b0;
        for (int c = 0; c < 3; c++) begin
            load(c, 16'h0002); pulse(4'h1 << c);
            check("gp_out", 16'h0000, gp_out[c]);
            check("gp_count", 16'h0001, gp_cnt[c*16 +: 16]);
            pulse(4'h1 << c);
            check("gp_out", 16'h0001, gp_out[c]);
        end
        // rate mode on channel 0: pulses at terminal count, reloads, drops on next tick
        gp_mode = 6'h01;
        load(0, 16'h0002);
        pulse(4'h1);
        pulse(4'h1);
        check("gp_rate_out", 16'h0001, gp_out[0]);
        pulse(4'h1);
        check("gp_rate_out", 16'h0000, gp_out[0]);
        check("gp_rate_count", 16'h0001, gp_cnt[15:0]);
        gp_mode = 6'h00;
        $display("test counters done");
    endtask
    task t_clk;
        for (int s = 0; s < 4; s++) begin
            sel = s;
            period("pad_base", 0, 50 << s);
        end
        sel = 2'h1;
        period("pad_div10", 1, 1000);
        period("pad_div100", 2, 10000);
        // the pacer never stops once loaded, so it runs last
        load(4, 16'h0002); load(5, 16'h0003);
        period("pacer", 3, 150);
        $display("test clocks done");
    endtask
    initial begin
        step(2);
        reset_n = 1'b1;
        step(1);
        t_out;
        t_rst;
        t_in;
        t_evt;
        t_clk;
        tally_and_finish;
    end
endmodule
